// ### pkg/tcc_regs.svh
// constants for the tdm channel control and cpu port block
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// register indices in cpu register space
`define TCC_REG_MODE 3'h0
`define TCC_REG_CTRL 3'h1
`define TCC_REG_TIM 3'h2
`define TCC_REG_GP 3'h3
`define TCC_REG_ALARM 3'h4
// reset values
`define TCC_MODE_RST 8'h60
`define TCC_ZERO_RST 8'h00
// mode register fields
`define TCC_MODE_RATE_LO 0
`define TCC_MODE_RATE_HI 1
`define TCC_MODE_FDS 2
// control register fields
`define TCC_CTRL_SEL_LO 0
`define TCC_CTRL_SEL_HI 2
`define TCC_CTRL_PAGE0 3
`define TCC_CTRL_PAGE1 4
// latched address fields
`define TCC_ADDR_SPACE 7
// connection memory high byte fields
`define TCC_CM_OE 8
`define TCC_CM_MSG 9
`define TCC_CM_DIR 10
`define TCC_CM_SRC8 10
`endif

// ### pkg/tcc_pkg.sv
// types for the tdm channel control and cpu port block
package tcc_pkg;
   // serial rate codes
   typedef enum logic [1:0] {
      TCC_R2M = 2'b00,
      TCC_R4M = 2'b01,
      TCC_R8M = 2'b10,
      TCC_RSV = 2'b11
   } tcc_rate_e;
   // memory select codes
   typedef enum logic [2:0] {
      TCC_TCM_LO = 3'b000,
      TCC_TCM_HI = 3'b001,
      TCC_RCM_LO = 3'b010,
      TCC_RCM_HI = 3'b011,
      TCC_TDM = 3'b100,
      TCC_RDM = 3'b101,
      TCC_NS6 = 3'b110,
      TCC_NS7 = 3'b111
   } tcc_sel_e;
   // cpu port states
   typedef enum logic [1:0] {
      TCC_IDLE = 2'b00,
      TCC_WAIT = 2'b01,
      TCC_ACK = 2'b10,
      TCC_REL = 2'b11
   } tcc_cpu_e;
   typedef logic [8:0] tcc_idx_t;
endpackage : tcc_pkg

// ### pkg/tcc_stream_if.sv
// valid/ready carrier between the block's own modules
`timescale 1ns/1ps
interface tcc_stream_if #(parameter int W = 8);
   logic valid; // word offered
   logic ready; // word accepted
   logic [W-1:0] data; // payload
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface : tcc_stream_if

// ### rtl/tcc_pair_buf.sv
// two-entry buffer in the serial output path
`timescale 1ns/1ps
module tcc_pair_buf #(parameter int W = 10, parameter int DEPTH = 2)(
   input wire logic clk_in,
   input wire logic srst_in,
   tcc_stream_if.snk fill_if,
   tcc_stream_if.src drain_if
);
   localparam int AW = $clog2(DEPTH);
   // -----------------------------------------------
   // storage and pointers
   // -----------------------------------------------
   logic [W-1:0] mem_ff [DEPTH]; // entries
   logic [AW-1:0] wr_ff; // fill pointer
   logic [AW-1:0] rd_ff; // drain pointer
   logic [AW:0] cnt_ff; // occupancy
   logic push;
   logic pop;
   // honest full/empty straight from the count
   assign fill_if.ready = (cnt_ff != (AW+1)'(DEPTH));
   assign drain_if.valid = (cnt_ff != '0);
   assign drain_if.data = mem_ff[rd_ff];
   assign push = fill_if.valid & fill_if.ready;
   assign pop = drain_if.valid & drain_if.ready;
   // pointers and count
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         if (pop)
            rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // entry write, no reset needed on data
   always_ff @(posedge clk_in)
   begin
      if (push)
         mem_ff[wr_ff] <= fill_if.data;
   end
endmodule : tcc_pair_buf

// ### rtl/tcc_top.sv
// tdm channel control, serial addressing and multiplexed cpu port
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_top #(parameter int DEPTH = 512)(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [7:0] cpu_ad_in,
   output logic [7:0] cpu_ad_out,
   output logic cpu_ad_oe_out,
   input wire logic address_latch_strobe_in,
   input wire logic data_read_strobe_in,
   input wire logic direction_write_strobe_in,
   input wire logic chip_select_n_in,
   output logic transfer_ack_n_out,
   output logic transfer_ack_oe_out,
   input wire logic tdm_clocks_ok_in,
   input wire logic slot_valid_in,
   output logic slot_ready_out,
   input wire logic [3:0] slot_stream_in,
   input wire logic [6:0] slot_chan_in,
   input wire logic [7:0] so_pin_byte_in,
   input wire logic [7:0] si_pin_byte_in,
   output logic ser_valid_out,
   input wire logic ser_ready_in,
   output logic [7:0] ser_byte_out,
   output logic so_oe_out,
   output logic si_oe_out,
   input wire logic ptx_valid_in,
   input wire tcc_pkg::tcc_idx_t ptx_idx_in,
   output logic ptx_valid_out,
   output logic [7:0] ptx_byte_out,
   output logic ptx_oe_out,
   input wire logic prx_valid_in,
   input wire tcc_pkg::tcc_idx_t prx_idx_in,
   input wire logic [7:0] prx_byte_in
);
   import tcc_pkg::*;
   // -----------------------------------------------
   // pin synchronisers
   // -----------------------------------------------
   logic [12:0] pin_s1_ff; // first stage, read only by second
   logic [12:0] pin_s2_ff; // usable copy
   logic [7:0] ad_s;
   logic ale_s;
   logic rd_s;
   logic wr_s;
   logic cs_n_s;
   logic clk_ok_s;
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         // idle pin levels, latch strobe low: no false fall after reset
         pin_s1_ff <= 13'h1ff7;
         pin_s2_ff <= 13'h1ff7;
      end
      else
      begin
         pin_s1_ff <= {tdm_clocks_ok_in, cpu_ad_in, address_latch_strobe_in,
                       data_read_strobe_in, direction_write_strobe_in,
                       chip_select_n_in};
         pin_s2_ff <= pin_s1_ff;
      end
   end
   assign {clk_ok_s, ad_s, ale_s, rd_s, wr_s, cs_n_s} = pin_s2_ff;
   // -----------------------------------------------
   // registers and mode decode
   // -----------------------------------------------
   logic [7:0] mode_ff; // rate and direction mode
   logic [7:0] ctrl_ff; // memory select and page
   logic [7:0] tim_ff; // timing mode, stored only
   logic [7:0] gp_ff; // general purpose, stored only
   logic [7:0] alarm_ff; // alarm/mask, stored only
   tcc_rate_e rate;
   logic fds;
   logic adrop; // add/drop in force
   logic bal2m; // 2M balanced, 256-channel map
   assign rate = tcc_rate_e'(mode_ff[`TCC_MODE_RATE_HI:`TCC_MODE_RATE_LO]);
   assign fds = mode_ff[`TCC_MODE_FDS];
   // add/drop only honoured at the lowest rate
   assign adrop = fds & (rate == TCC_R2M);
   assign bal2m = ~fds & (rate == TCC_R2M);
   // -----------------------------------------------
   // memories
   // -----------------------------------------------
   logic [15:0] tcm_mem [DEPTH]; // transmit_connection_memory
   logic [15:0] rcm_mem [DEPTH]; // receive_connection_memory
   logic [7:0] tdm_mem [DEPTH]; // transmit_data_memory
   logic [7:0] rdm_mem [DEPTH]; // receive_data_memory
   // -----------------------------------------------
   // serial slot path
   // -----------------------------------------------
   tcc_idx_t s_idx; // memory index of the slot
   logic [15:0] s_ent;
   logic [7:0] s_out; // byte to drive
   logic [7:0] s_store; // byte written to tx data memory
   logic s_so_oe;
   logic s_si_oe;
   logic s_fire;
   // stream/channel packing per rate
   always_comb
   begin
      unique case (rate)
         TCC_R4M: s_idx = {slot_stream_in[2:0], slot_chan_in[5:0]};
         TCC_R8M: s_idx = {slot_stream_in[1:0], slot_chan_in[6:0]};
         default:
         begin
            if (adrop)
               s_idx = {slot_stream_in[3:0], slot_chan_in[4:0]};
            else
               s_idx = {1'b0, slot_stream_in[2:0], slot_chan_in[4:0]};
         end
      endcase
   end
   assign s_ent = rcm_mem[s_idx];
   // message byte comes from the entry itself every frame
   assign s_out = s_ent[`TCC_CM_MSG] ? s_ent[7:0] : rdm_mem[{1'b0, s_ent[7:0]}];
   // direction and drive per slot; drive bit gates both pin enables
   always_comb
   begin
      if (adrop)
      begin
         // streams 8..15 are the nominal input pins
         s_so_oe = s_ent[`TCC_CM_OE] & s_ent[`TCC_CM_DIR] & ~slot_stream_in[3];
         s_si_oe = s_ent[`TCC_CM_OE] & s_ent[`TCC_CM_DIR] & slot_stream_in[3];
         // every channel lands in tx data, driven ones copied back
         if (s_so_oe | s_si_oe)
            s_store = s_out;
         else
            s_store = slot_stream_in[3] ? si_pin_byte_in : so_pin_byte_in;
      end
      else
      begin
         s_so_oe = s_ent[`TCC_CM_OE] & s_ent[`TCC_CM_DIR];
         s_si_oe = s_ent[`TCC_CM_OE] & ~s_ent[`TCC_CM_DIR];
         // low direction: output pin's data becomes the input
         s_store = s_ent[`TCC_CM_DIR] ? si_pin_byte_in : so_pin_byte_in;
      end
   end
   // buffer keeps a slot's result whole while the receiver stalls
   tcc_stream_if #(.W(10)) ser_fill_if();
   tcc_stream_if #(.W(10)) ser_drain_if();
   assign ser_fill_if.valid = slot_valid_in;
   assign ser_fill_if.data = {s_out, s_so_oe, s_si_oe};
   assign slot_ready_out = ser_fill_if.ready;
   assign s_fire = slot_valid_in & ser_fill_if.ready;
   assign ser_valid_out = ser_drain_if.valid;
   assign ser_drain_if.ready = ser_ready_in;
   // oe stays low for the entry's whole slot when not driving
   assign ser_byte_out = ser_drain_if.data[9:2];
   assign so_oe_out = ser_drain_if.valid & ser_drain_if.data[1];
   assign si_oe_out = ser_drain_if.valid & ser_drain_if.data[0];
   tcc_pair_buf #(.W(10), .DEPTH(2)) u_ser_buf (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .fill_if(ser_fill_if.snk),
      .drain_if(ser_drain_if.src)
   );
   // -----------------------------------------------
   // parallel transmit slot path
   // -----------------------------------------------
   logic [15:0] p_ent;
   tcc_idx_t p_src;
   assign p_ent = tcm_mem[ptx_idx_in];
   // source is 8 bits in the 256-channel map, else 9
   assign p_src = bal2m ? {1'b0, p_ent[7:0]} : {p_ent[`TCC_CM_SRC8], p_ent[7:0]};
   // one-cycle registered output per requested slot
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ptx_valid_out <= 1'b0;
         ptx_byte_out <= 8'h00;
         ptx_oe_out <= 1'b0;
      end
      else
      begin
         ptx_valid_out <= ptx_valid_in;
         ptx_byte_out <= p_ent[`TCC_CM_MSG] ? p_ent[7:0] : tdm_mem[p_src];
         ptx_oe_out <= ptx_valid_in & p_ent[`TCC_CM_OE];
      end
   end
   // -----------------------------------------------
   // cpu bus cycle decode
   // -----------------------------------------------
   logic ale_d_ff; // previous latch strobe
   logic [7:0] addr_ff; // latched address
   logic split_ff; // separate read/write strobe family
   logic cyc_rd;
   logic cyc_wr;
   logic cyc_on;
   // family guessed from idle strobe level at address latch
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ale_d_ff <= 1'b0;
         addr_ff <= 8'h00;
         split_ff <= 1'b1;
      end
      else
      begin
         ale_d_ff <= ale_s;
         if (ale_d_ff & ~ale_s)
         begin
            addr_ff <= ad_s;
            split_ff <= rd_s;
         end
      end
   end
   // split family: active-low strobes; else high strobe with r/w level
   assign cyc_rd = ~cs_n_s & (split_ff ? ~rd_s : (rd_s & wr_s));
   assign cyc_wr = ~cs_n_s & (split_ff ? ~wr_s : (rd_s & ~wr_s));
   assign cyc_on = cyc_rd | cyc_wr;
   // -----------------------------------------------
   // memory addressing and arbitration
   // -----------------------------------------------
   logic is_mem;
   tcc_sel_e sel;
   tcc_idx_t c_idx; // memory index for the cpu
   logic mem_free; // no tdm access and clocks present
   assign is_mem = addr_ff[`TCC_ADDR_SPACE];
   assign sel = tcc_sel_e'(ctrl_ff[`TCC_CTRL_SEL_HI:`TCC_CTRL_SEL_LO]);
   // page bits are the low high-address bits of the control register
   assign c_idx = bal2m ? {1'b0, ctrl_ff[`TCC_CTRL_PAGE0], addr_ff[6:0]}
                        : {ctrl_ff[`TCC_CTRL_PAGE1], ctrl_ff[`TCC_CTRL_PAGE0], addr_ff[6:0]};
   // tdm slots always win the memory
   assign mem_free = ~(s_fire | ptx_valid_in | prx_valid_in) & clk_ok_s;
   // -----------------------------------------------
   // cpu port state machine and write pipeline
   // -----------------------------------------------
   tcc_cpu_e st_ff;
   tcc_cpu_e nxt_st;
   logic pipe_v_ff; // one byte waiting for the memory
   tcc_sel_e pipe_sel_ff;
   tcc_idx_t pipe_idx_ff;
   logic [7:0] pipe_dat_ff;
   logic [7:0] rdata_ff; // read data held on the bus
   logic rd_cyc_ff; // current cycle is a read
   logic go_reg;
   logic go_mwr;
   logic rd_done;
   logic drain;
   logic [7:0] reg_rd;
   logic [7:0] mem_rd;
   // a busy pipeline blocks registers too, so a hung write shows
   assign go_reg = (st_ff == TCC_IDLE) & cyc_on & ~is_mem & ~pipe_v_ff;
   assign go_mwr = (st_ff == TCC_IDLE) & cyc_wr & is_mem & ~pipe_v_ff;
   assign rd_done = (st_ff == TCC_WAIT) & cyc_rd & mem_free & ~pipe_v_ff;
   assign drain = pipe_v_ff & mem_free;
   // next state
   always_comb
   begin
      nxt_st = st_ff;
      unique case (st_ff)
         TCC_IDLE:
         begin
            if (go_reg | go_mwr)
               nxt_st = TCC_ACK;
            else if (cyc_rd & is_mem)
               nxt_st = TCC_WAIT;
         end
         // ending the read clears a wait on a missing clock
         TCC_WAIT: nxt_st = ~cyc_rd ? TCC_IDLE : (rd_done ? TCC_ACK : TCC_WAIT);
         TCC_ACK: nxt_st = cyc_on ? TCC_ACK : TCC_REL;
         TCC_REL: nxt_st = TCC_IDLE;
      endcase
   end
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         st_ff <= TCC_IDLE;
      else
         st_ff <= nxt_st;
   end
   // register read mux, unused indices read zero
   always_comb
   begin
      unique case (addr_ff[2:0])
         `TCC_REG_MODE: reg_rd = mode_ff;
         `TCC_REG_CTRL: reg_rd = ctrl_ff;
         `TCC_REG_TIM: reg_rd = tim_ff;
         `TCC_REG_GP: reg_rd = gp_ff;
         `TCC_REG_ALARM: reg_rd = alarm_ff;
         default: reg_rd = 8'h00;
      endcase
   end
   // memory read mux by select code
   always_comb
   begin
      unique case (sel)
         TCC_TCM_LO: mem_rd = tcm_mem[c_idx][7:0];
         TCC_TCM_HI: mem_rd = tcm_mem[c_idx][15:8];
         TCC_RCM_LO: mem_rd = rcm_mem[c_idx][7:0];
         TCC_RCM_HI: mem_rd = rcm_mem[c_idx][15:8];
         TCC_TDM: mem_rd = tdm_mem[c_idx];
         TCC_RDM: mem_rd = rdm_mem[c_idx];
         default: mem_rd = 8'h00;
      endcase
   end
   // read data capture and cycle direction
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         rdata_ff <= 8'h00;
         rd_cyc_ff <= 1'b0;
      end
      else
      begin
         if (go_reg)
            rdata_ff <= reg_rd;
         else if (rd_done)
            rdata_ff <= mem_rd;
         if (st_ff == TCC_IDLE)
            rd_cyc_ff <= cyc_rd;
      end
   end
   // registers; mode must be set before receive map writes
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         mode_ff <= `TCC_MODE_RST;
         ctrl_ff <= `TCC_ZERO_RST;
         tim_ff <= `TCC_ZERO_RST;
         gp_ff <= `TCC_ZERO_RST;
         alarm_ff <= `TCC_ZERO_RST;
      end
      else if (go_reg & cyc_wr)
      begin
         unique case (addr_ff[2:0])
            `TCC_REG_MODE: mode_ff <= ad_s;
            `TCC_REG_CTRL: ctrl_ff <= ad_s;
            `TCC_REG_TIM: tim_ff <= ad_s;
            `TCC_REG_GP: gp_ff <= ad_s;
            `TCC_REG_ALARM: alarm_ff <= ad_s;
            default: ;
         endcase
      end
   end
   // single-byte write pipeline, acked at register speed
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pipe_v_ff <= 1'b0;
         pipe_sel_ff <= TCC_TCM_LO;
         pipe_idx_ff <= '0;
         pipe_dat_ff <= 8'h00;
      end
      else if (go_mwr)
      begin
         // data memories are read-only: write acked, not queued
         pipe_v_ff <= (sel inside {TCC_TCM_LO, TCC_TCM_HI, TCC_RCM_LO, TCC_RCM_HI});
         pipe_sel_ff <= sel;
         pipe_idx_ff <= c_idx;
         pipe_dat_ff <= ad_s;
      end
      else if (drain)
         pipe_v_ff <= 1'b0;
   end
   // memory writes; tdm and cpu never share a cycle
   always_ff @(posedge clk_in)
   begin
      if (s_fire)
         tdm_mem[s_idx] <= s_store;
      if (prx_valid_in)
         rdm_mem[prx_idx_in] <= prx_byte_in;
      if (drain)
      begin
         unique case (pipe_sel_ff)
            TCC_TCM_LO: tcm_mem[pipe_idx_ff][7:0] <= pipe_dat_ff;
            TCC_TCM_HI: tcm_mem[pipe_idx_ff][15:8] <= pipe_dat_ff;
            TCC_RCM_LO: rcm_mem[pipe_idx_ff][7:0] <= pipe_dat_ff;
            TCC_RCM_HI: rcm_mem[pipe_idx_ff][15:8] <= pipe_dat_ff;
            default: ;
         endcase
      end
   end
   // -----------------------------------------------
   // bus outputs
   // -----------------------------------------------
   assign cpu_ad_out = rdata_ff;
   assign cpu_ad_oe_out = (st_ff == TCC_ACK) & rd_cyc_ff;
   assign transfer_ack_n_out = (st_ff != TCC_ACK);
   assign transfer_ack_oe_out = (st_ff == TCC_ACK) | (st_ff == TCC_REL);
endmodule : tcc_top

// ### tb/tcc_checker.sv
// concurrent checks on the top ports
`timescale 1ns/1ps
module tcc_checker(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [7:0] cpu_ad_out,
   input wire logic cpu_ad_oe_out,
   input wire logic transfer_ack_n_out,
   input wire logic transfer_ack_oe_out,
   input wire logic slot_valid_in,
   input wire logic slot_ready_out,
   input wire logic ser_valid_out,
   input wire logic ser_ready_in,
   input wire logic [7:0] ser_byte_out,
   input wire logic so_oe_out,
   input wire logic si_oe_out,
   input wire logic ptx_valid_in,
   input wire logic ptx_valid_out
);
   // -------------
   // buffer count
   // -------------
   logic [1:0] occ_ff; // words held in the two-entry buffer
   always_ff @(posedge clk_in)
      if (srst_in) occ_ff <= 2'h0;
      else occ_ff <= occ_ff + 2'(slot_valid_in && slot_ready_out)
         - 2'(ser_valid_out && ser_ready_in);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // -----------
   // properties
   // -----------
   AST_BUF_READY: assert property (slot_ready_out == (occ_ff != 2'h2))
      else $error("slot ready wrong for buffer fill");
   AST_BUF_VALID: assert property (ser_valid_out == (occ_ff != 2'h0))
      else $error("result valid wrong for buffer fill");
   AST_SER_HOLD: assert property (ser_valid_out && !ser_ready_in |=> ser_valid_out
      && $stable(ser_byte_out) && $stable(so_oe_out)) else $error("stalled result moved");
   AST_OE_EXCL: assert property (ser_valid_out |-> !(so_oe_out && si_oe_out))
      else $error("both pins driven in one slot");
   AST_PTX_LAT: assert property (ptx_valid_in |=> ptx_valid_out)
      else $error("parallel slot answer late");
   AST_PTX_ONE: assert property (!ptx_valid_in |=> !ptx_valid_out)
      else $error("parallel answer without request");
   AST_AD_OE: assert property (cpu_ad_oe_out |-> transfer_ack_oe_out && !transfer_ack_n_out)
      else $error("bus driven outside ack");
   AST_AD_STABLE: assert property (cpu_ad_oe_out ##1 cpu_ad_oe_out |-> $stable(cpu_ad_out))
      else $error("read data moved during ack");
   AST_ACK_FALL: assert property ($fell(transfer_ack_n_out) |-> transfer_ack_oe_out)
      else $error("ack low while released");
   AST_ACK_REL: assert property ($rose(transfer_ack_n_out) |-> transfer_ack_oe_out ##1
      !transfer_ack_oe_out) else $error("ack not driven high then released");
   AST_ACK_IDLE: assert property (!transfer_ack_oe_out |-> transfer_ack_n_out)
      else $error("ack level low while released");
endmodule : tcc_checker

// ### tb/tcc_cpu_model.sv
// behavioural cpu on the multiplexed address/data bus
`timescale 1ns/1ps
module tcc_cpu_model(
   input wire logic clk_in,
   input wire logic [7:0] bus_in,
   input wire logic ack_n_in,
   input wire logic ack_oe_in,
   output logic [7:0] drv_out,
   output logic ale_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic cs_n_out
);
   logic ds_mode = 1'b0; // high: strobe-high family with read/write level
   // idle levels
   initial
   begin
      drv_out = 8'h00;
      ale_out = 1'b0;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      cs_n_out = 1'b1;
   end
   // one cycle in the family ds_mode selects; read strobe high at latch picks split strobes
   task automatic cyc(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r, output logic ok);
      int i;
      ok = 1'b0;
      r = 8'h00;
      @(posedge clk_in) #1;
      drv_out = a;
      rd_n_out = !ds_mode;
      ale_out = 1'b1;
      @(posedge clk_in) #1;
      ale_out = 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      cs_n_out = 1'b0;
      rd_n_out = ds_mode | wr;
      wr_n_out = !wr;
      drv_out = wr ? d : ~a; // a released bus must not look like the address
      for (i = 0; i < 64 && ok !== 1'b1; i++)
      begin
         @(posedge clk_in);
         ok = (ack_n_in === 1'b0);
         r = bus_in;
      end
      #1;
      cs_n_out = 1'b1;
      rd_n_out = !ds_mode;
      wr_n_out = 1'b1;
      drv_out = ~drv_out;
      for (i = 0; i < 16 && ack_oe_in !== 1'b0; i++) @(posedge clk_in);
      repeat (2) @(posedge clk_in);
      #1;
   endtask : cyc
endmodule : tcc_cpu_model

// ### tb/tcc_top_tb_top.sv
// self-checking bench for the tdm channel control block
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_top_tb_top;
   import tcc_pkg::*;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic tdm_clocks_ok_in = 1'b1;
   logic slot_valid_in = 1'b0;
   logic ser_ready_in = 1'b0;
   logic ptx_valid_in = 1'b0;
   logic prx_valid_in = 1'b0;
   logic [3:0] slot_stream_in = 4'h0;
   logic [6:0] slot_chan_in = 7'h00;
   logic [7:0] so_pin_byte_in = 8'h00;
   logic [7:0] si_pin_byte_in = 8'h00;
   logic [7:0] prx_byte_in = 8'h00;
   tcc_idx_t ptx_idx_in = 9'h000;
   tcc_idx_t prx_idx_in = 9'h000;
   logic [7:0] cpu_ad_in, cpu_ad_out, drv, ser_byte_out, ptx_byte_out;
   logic address_latch_strobe_in, data_read_strobe_in, direction_write_strobe_in;
   logic chip_select_n_in, cpu_ad_oe_out, transfer_ack_n_out, transfer_ack_oe_out;
   logic slot_ready_out, ser_valid_out, so_oe_out, si_oe_out, ptx_valid_out, ptx_oe_out;
   int n_errors = 0;
   int comparisons = 0;
   int seed = 28;
   // wire level: device while it drives, else the cpu
   assign cpu_ad_in = cpu_ad_oe_out ? cpu_ad_out : drv;
   always #2.5 clk_in = ~clk_in;
   tcc_top i_tcc_top(.*);
   tcc_cpu_model i_tcc_cpu_model(.clk_in(clk_in), .bus_in(cpu_ad_in),
      .ack_n_in(transfer_ack_n_out), .ack_oe_in(transfer_ack_oe_out), .drv_out(drv),
      .ale_out(address_latch_strobe_in), .rd_n_out(data_read_strobe_in),
      .wr_n_out(direction_write_strobe_in), .cs_n_out(chip_select_n_in));
   task close_out;
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   task hang;
      n_errors++;
      close_out;
   endtask : hang
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task chkb(input string what, input logic exp, input logic got);
      chk(what, {7'h00, exp}, {7'h00, got});
   endtask : chkb
   task acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      logic ok;
      i_tcc_cpu_model.cyc(wr, a, d, r, ok);
      chkb("ack", 1'b1, ok);
   endtask : acc
   // select memory and page, then one access in memory space
   task mem(input logic wr, input tcc_sel_e s, input tcc_idx_t x, input logic [7:0] d,
      output logic [7:0] r);
      acc(1'b1, {5'h00, `TCC_REG_CTRL}, {3'h0, x[8:7], s}, r);
      acc(wr, {1'b1, x[6:0]}, d, r);
   endtask : mem
   task drain(output logic [7:0] b, output logic so, output logic si);
      int i;
      @(posedge clk_in) #1;
      for (i = 0; i < 32 && ser_valid_out !== 1'b1; i++) @(posedge clk_in) #1;
      if (i == 32) hang;
      b = ser_byte_out;
      so = so_oe_out;
      si = si_oe_out;
      ser_ready_in = 1'b1;
      @(posedge clk_in) #1;
      ser_ready_in = 1'b0;
   endtask : drain
   task slot(input logic [10:0] sc, input logic [7:0] sop, input logic tk,
      output logic [7:0] b, output logic so, output logic si);
      int i;
      @(posedge clk_in) #1;
      slot_valid_in = 1'b1;
      {slot_stream_in, slot_chan_in} = sc;
      so_pin_byte_in = sop;
      si_pin_byte_in = ~sop;
      for (i = 0; i < 32 && slot_ready_out !== 1'b1; i++) @(posedge clk_in) #1;
      if (i == 32) hang;
      @(posedge clk_in) #1;
      slot_valid_in = 1'b0;
      if (tk) drain(b, so, si);
   endtask : slot
   // stream and channel of a slot for mode m (2M bal, add/drop, 4M, 8M)
   function automatic logic [10:0] slot_of(input int m, input tcc_idx_t x);
      case (m)
         0: return {1'b0, x[7:5], 2'h0, x[4:0]};
         1: return {x[8:5], 2'h0, x[4:0]};
         2: return {1'b0, x[8:6], 1'b0, x[5:0]};
         default: return {2'h0, x[8:7], x[6:0]};
      endcase
   endfunction : slot_of
   initial
   begin
      logic [7:0] r, msg, sop, d, b;
      logic so, si, ok;
      tcc_idx_t x;
      logic [10:0] sc;
      repeat (16) @(posedge clk_in);
      #1;
      srst_in = 1'b0;
      repeat (3) @(posedge clk_in);
      acc(1'b0, {5'h00, `TCC_REG_MODE}, 8'h00, r);
      chk("mode_rst", `TCC_MODE_RST, r);
      acc(1'b1, {5'h00, `TCC_REG_TIM}, 8'h5a, r);
      acc(1'b0, {5'h00, `TCC_REG_TIM}, 8'h00, r);
      chk("tim", 8'h5a, r);
      acc(1'b0, 8'h06, 8'h00, r);
      chk("reserved", 8'h00, r);
      // other bus family: data strobe high with a read/write level
      i_tcc_cpu_model.ds_mode = 1'b1;
      acc(1'b1, {5'h00, `TCC_REG_GP}, 8'ha5, r);
      acc(1'b0, {5'h00, `TCC_REG_GP}, 8'h00, r);
      chk("ds_family", 8'ha5, r);
      i_tcc_cpu_model.ds_mode = 1'b0;
      for (int m = 0; m < 4; m++)
      begin
         x = tcc_idx_t'($random(seed));
         if (m < 2) x[8] = 1'b0;
         msg = 8'($random(seed));
         sop = 8'($random(seed));
         d = 8'($random(seed));
         sc = slot_of(m, x);
         // serial mode is set before any connection entry
         acc(1'b1, {5'h00, `TCC_REG_MODE}, {5'h0c, m == 1, m > 1 ? 2'(m - 1) : 2'h0}, r);
         mem(1'b1, TCC_RCM_LO, x, msg, r);
         mem(1'b1, TCC_RCM_HI, x, 8'h07, r);
         repeat (2)
         begin
            slot(sc, sop, 1'b1, b, so, si);
            chk("msg", msg, b);
            chkb("so_oe", 1'b1, so);
            chkb("si_oe", 1'b0, si);
         end
         if (m == 1) mem(1'b0, TCC_TDM, x, 8'h00, r);
         if (m == 1) chk("copy", msg, r);
         mem(1'b1, TCC_RCM_HI, x, 8'h06, r);
         slot(sc, sop, 1'b1, b, so, si);
         chkb("so_off", 1'b0, so);
         chkb("si_off", 1'b0, si);
         mem(1'b1, TCC_RCM_HI, x, 8'h03, r);
         slot(sc, sop, 1'b1, b, so, si);
         chkb("so_in", 1'b0, so);
         chkb("si_out", m != 1, si);
         mem(1'b0, TCC_TDM, x, 8'h00, r);
         chk("store", sop, r);
         mem(1'b1, TCC_TDM, x, ~sop, r);
         mem(1'b0, TCC_TDM, x, 8'h00, r);
         chk("data_ro", sop, r);
         mem(1'b0, TCC_RCM_LO, x, 8'h00, r);
         chk("conn_rw", msg, r);
         prx_valid_in = 1'b1;
         prx_idx_in = {1'b0, msg};
         prx_byte_in = d;
         @(posedge clk_in) #1;
         prx_valid_in = 1'b0;
         mem(1'b1, TCC_RCM_HI, x, 8'h05, r);
         slot(sc, sop, 1'b1, b, so, si);
         chk("source", d, b);
         mem(1'b1, TCC_TCM_LO, x, sop, r);
         mem(1'b1, TCC_TCM_HI, x, 8'h03, r);
         ptx_idx_in = x;
         ptx_valid_in = 1'b1;
         @(posedge clk_in) #1;
         ptx_valid_in = 1'b0;
         chkb("ptx", 1'b1, ptx_valid_out);
         chk("ptx_msg", sop, ptx_byte_out);
         chkb("ptx_oe", 1'b1, ptx_oe_out);
      end
      // fill the buffer with the receiver stalled, then empty it
      slot(sc, sop, 1'b0, b, so, si);
      slot(sc, sop, 1'b0, b, so, si);
      chkb("full", 1'b0, slot_ready_out);
      drain(b, so, si);
      drain(b, so, si);
      chk("drained", d, b);
      // memory read with the tdm clocks gone never completes
      mem(1'b0, TCC_RCM_LO, x, 8'h00, r);
      tdm_clocks_ok_in = 1'b0;
      i_tcc_cpu_model.cyc(1'b0, {1'b1, x[6:0]}, 8'h00, r, ok);
      chkb("stall", 1'b0, ok);
      tdm_clocks_ok_in = 1'b1;
      mem(1'b0, TCC_RCM_LO, x, 8'h00, r);
      chk("resume", msg, r);
      close_out;
   end
endmodule : tcc_top_tb_top
bind tcc_top tcc_checker i_tcc_checker(.*);
